/* File: core/tdroc_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes inputs are levels slower than the clock; no reset needed.
module tdroc_sync #(
   parameter int W = 1                 // Number of bits
)
(
   input  logic         clk,           // System clock
   input  logic [W-1:0] d,             // Asynchronous inputs
   output logic [W-1:0] q              // Synchronised outputs
);

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [W-1:0] s1;                // First stage, read by s2 only
      logic [W-1:0] s2;                // Second stage
   } tdroc_sync_s;

   tdroc_sync_s st_reg;                // Registered state
   tdroc_sync_s st_next;               // Next state

   // Shift the pins through both stages
   always_comb
   begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   // Register the state
   always_ff @(posedge clk)
   begin
      st_reg <= st_next;
   end

   assign q = st_reg.s2;

endmodule

/* File: core/tdroc_tick.sv */
// Divider giving a one-cycle enable pulse every DIV cycles.
// Assumes en stays high for a whole run; dropping it restarts the count.
module tdroc_tick #(
   parameter int DIV = 63              // Cycles between pulses
)
(
   input  logic clk,                   // System clock
   input  logic srst,                  // Synchronous reset
   input  logic en,                    // Run the divider
   output logic tick                   // Enable pulse
);

   localparam int CW = $clog2(DIV + 1);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;              // Cycle count
   } tdroc_tick_s;

   tdroc_tick_s st_reg;                // Registered state
   tdroc_tick_s st_next;               // Next state

   // Pulse on the last count of each period
   assign tick = en && (st_reg.cnt == LAST);

   // Count while enabled, so the first pulse is a full period away
   always_comb
   begin
      st_next = st_reg;
      if (!en || tick)
         st_next.cnt = '0;
      else
         st_next.cnt = st_reg.cnt + 1'b1;
      if (srst)
         st_next.cnt = '0;
   end

   // Register the state
   always_ff @(posedge clk)
   begin
      st_reg <= st_next;
   end

endmodule

/* File: core/tdroc_top.sv */
// Decoder reset sequencer with address translator gating, plus laser
// control, status and a serial master for the optical sockets.
// Assumes all pin inputs are asynchronous; requests are on CLK_SYS.
module tdroc_top (
   input  logic                  CLK_SYS,          // 100 MHz clock
   input  logic                  SRST,             // Sync reset
   input  logic                  DEC_RST_REQ,      // Start decoder reset
   output logic                  TIMING_DECODER_RESET_N, // To decoder
   output logic                  GA_XLAT_OE_N,     // Translator enable
   output logic                  DEC_RST_BUSY,     // Sequence running
   input  logic [3:0]            LASER_OFF,        // Laser off request
   output logic [3:0]            OPT_TX_DISABLE,   // Laser disable pins
   input  logic [3:0]            OPT_TX_FAULT,     // Laser fault pins
   input  logic [3:0]            MODULE_PRESENT_N, // Presence pins
   input  logic [3:0]            OPT_SDA_IN,       // Serial data in
   output logic [3:0]            OPT_SDA_OUT,      // Serial data out
   output logic [3:0]            OPT_SDA_OE_N,     // Low pulls SDA low
   output logic [3:0]            OPT_SCL,          // Serial clocks
   output tdroc_pkg::tdroc_sts_s OPT_STS,          // Socket status
   input  logic                  TWI_REQ,          // Command valid
   input  tdroc_pkg::tdroc_cmd_s TWI_CMD,          // Command
   output logic                  TWI_READY,        // Command accepted
   output logic                  TWI_DONE,         // Command finished
   output tdroc_pkg::tdroc_rsp_s TWI_RSP           // Result
);

   // ***********************************************************
   // Constants
   // ***********************************************************
   localparam int N  = tdroc_pkg::N_OPT;
   localparam int LW = tdroc_pkg::LANE_W;   // Socket index width
   localparam int CW = tdroc_pkg::SEQ_CW;
   localparam logic [CW-1:0] SETUP_LAST = CW'(tdroc_pkg::SETUP_CYC - 1);
   localparam logic [CW-1:0] HOLD_LAST  = CW'(tdroc_pkg::HOLD_CYC - 1);
   localparam logic [CW-1:0] TAIL_LAST  = CW'(tdroc_pkg::TAIL_CYC - 1);
   localparam logic [3:0]    SLOT_LAST  = 4'(tdroc_pkg::TWI_SLOTS - 1);

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      tdroc_pkg::tdroc_seq_e sq;       // Reset sequencer state
      logic [CW-1:0]         cnt;      // Sequencer cycle count
      logic                  rst_n;    // Decoder reset level
      logic                  oe_n;     // Translator enable level
      logic [N-1:0]          tx_dis;   // Laser disable levels
      logic [N-1:0]          flt_d;    // Fault, one cycle late
      logic [N-1:0]          flt_evt;  // Fault rising edges
      logic                  busy;     // Serial operation running
      tdroc_pkg::tdroc_cmd_s cmd;      // Operation held
      logic [1:0]            qtr;      // Quarter of the bit
      logic [3:0]            slot;     // Bits left minus one
      logic [8:0]            shf;      // Bits out and in
      logic                  scl;      // Serial clock level
      logic                  sda;      // Serial data level
      logic [N-1:0]          scl_v;    // Per-socket clocks
      logic [N-1:0]          oe_v;     // Per-socket data enables
      logic                  done;     // Completion pulse
      tdroc_pkg::tdroc_rsp_s rsp;      // Result held
   } tdroc_main_s;

   tdroc_main_s r;                     // Registered state
   tdroc_main_s n;                     // Next state

   logic [N-1:0] flt_s;                // Synchronised faults
   logic [N-1:0] prs_n_s;              // Synchronised presence
   logic [N-1:0] sda_s;                // Synchronised data lines
   logic         tick;                 // Quarter-bit enable

   // ***********************************************************
   // Pin synchronisers and bit-rate divider
   // ***********************************************************
   tdroc_sync #(
      .W (3 * N)
   ) u_sync (
      .clk (CLK_SYS),
      .d   ({OPT_TX_FAULT, MODULE_PRESENT_N, OPT_SDA_IN}),
      .q   ({flt_s, prs_n_s, sda_s})
   );

   tdroc_tick #(
      .DIV (tdroc_pkg::TWI_QTR_CYC)
   ) u_tick (
      .clk  (CLK_SYS),
      .srst (SRST),
      .en   (r.busy),
      .tick (tick)
   );

   // ***********************************************************
   // Next-state logic
   // ***********************************************************
   always_comb
   begin
      n = r;
      n.done = 1'b0;

      // Reset sequencer: translator on, reset low, release, translator off
      case (r.sq)
         tdroc_pkg::SQ_IDLE:
         begin
            // A request outside the idle state is absorbed by the run
            if (DEC_RST_REQ)
            begin
               n.sq  = tdroc_pkg::SQ_SETUP;
               n.cnt = '0;
            end
         end
         tdroc_pkg::SQ_SETUP:
         begin
            // Address is driven before the decoder starts sampling
            if (r.cnt == SETUP_LAST)
            begin
               n.sq  = tdroc_pkg::SQ_HOLD;
               n.cnt = '0;
            end
            else
               n.cnt = r.cnt + 1'b1;
         end
         tdroc_pkg::SQ_HOLD:
         begin
            // Least hold of reset low
            if (r.cnt == HOLD_LAST)
            begin
               n.sq  = tdroc_pkg::SQ_TAIL;
               n.cnt = '0;
            end
            else
               n.cnt = r.cnt + 1'b1;
         end
         tdroc_pkg::SQ_TAIL:
         begin
            // Decoder captures at release, so keep the address a while
            if (r.cnt == TAIL_LAST)
            begin
               n.sq  = tdroc_pkg::SQ_IDLE;
               n.cnt = '0;
            end
            else
               n.cnt = r.cnt + 1'b1;
         end
         default:
         begin
            n.sq  = tdroc_pkg::SQ_IDLE;
            n.cnt = '0;
         end
      endcase

      // Reset low only in the hold state
      n.rst_n = (n.sq != tdroc_pkg::SQ_HOLD);
      // Only the address half is gated; strap bits are never driven here
      // so the address lands in word bits 12:6
      // Enable spans the whole reset, released before decoder drives
      n.oe_n  = (n.sq == tdroc_pkg::SQ_IDLE);

      // Socket status: fault edges and laser control
      n.flt_d   = flt_s;
      n.flt_evt = flt_s & ~r.flt_d;
      // Empty sockets keep the laser off as well
      n.tx_dis  = LASER_OFF | prs_n_s;

      // Serial master: accept a command when idle
      if (!r.busy)
      begin
         if (TWI_REQ)
         begin
            n.busy = 1'b1;
            n.cmd  = TWI_CMD;
            n.qtr  = 2'h0;
            if (TWI_CMD.op == tdroc_pkg::TW_WRITE ||
                TWI_CMD.op == tdroc_pkg::TW_READ)
               n.slot = SLOT_LAST;
            else
               n.slot = 4'h0;
            // A read releases the line for data, then sends its ack
            if (TWI_CMD.op == tdroc_pkg::TW_READ)
               n.shf = {8'hFF, TWI_CMD.ack};
            else
               n.shf = {TWI_CMD.data, 1'h1};
         end
      end
      else if (tick)
      begin
         n.qtr = r.qtr + 1'b1;
         case (r.qtr)
            2'h0:
            begin
               // Clock low, set the data line for this slot
               n.scl = 1'h0;
               case (r.cmd.op)
                  tdroc_pkg::TW_START: n.sda = 1'h1;
                  tdroc_pkg::TW_STOP:  n.sda = 1'h0;
                  default:             n.sda = r.shf[8];
               endcase
            end
            2'h1:
               n.scl = 1'h1;
            2'h2:
            begin
               // Data edge under high clock makes start and stop
               case (r.cmd.op)
                  tdroc_pkg::TW_START: n.sda = 1'h0;
                  tdroc_pkg::TW_STOP:  n.sda = 1'h1;
                  default:
                     n.shf = {r.shf[7:0], sda_s[r.cmd.lane]};
               endcase
            end
            default:
            begin
               // Stop leaves the clock high for the idle bus
               if (r.cmd.op != tdroc_pkg::TW_STOP)
                  n.scl = 1'h0;
               if (r.slot == 4'h0)
               begin
                  n.busy = 1'b0;
                  n.done = 1'b1;
                  n.rsp  = '{data: r.shf[8:1], nack: r.shf[0]};
               end
               else
                  n.slot = r.slot - 1'b1;
            end
         endcase
      end

      // Only the addressed socket sees the clock and data pull-down
      for (int i = 0; i < N; i++)
      begin
         if (n.cmd.lane == LW'(i))
         begin
            n.scl_v[i] = n.scl;
            n.oe_v[i]  = n.sda;
         end
         else
         begin
            n.scl_v[i] = tdroc_pkg::LINE_IDLE;
            n.oe_v[i]  = tdroc_pkg::LINE_IDLE;
         end
      end

      // Synchronous reset: start a decoder reset, lasers off, bus idle
      if (SRST)
      begin
         n       = '0;
         n.sq    = tdroc_pkg::SEQ_RST;
         n.rst_n = 1'b1;
         n.tx_dis = '1;
         n.scl   = tdroc_pkg::LINE_IDLE;
         n.sda   = tdroc_pkg::LINE_IDLE;
         n.scl_v = '1;
         n.oe_v  = '1;
      end
   end

   // Register the whole state
   always_ff @(posedge CLK_SYS)
   begin
      r <= n;
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign TIMING_DECODER_RESET_N = r.rst_n;
   assign GA_XLAT_OE_N           = r.oe_n;
   assign DEC_RST_BUSY           = (r.sq != tdroc_pkg::SQ_IDLE);
   assign OPT_TX_DISABLE         = r.tx_dis;
   assign OPT_SDA_OUT            = '0;        // Open drain pulls low only
   assign OPT_SDA_OE_N           = r.oe_v;
   assign OPT_SCL                = r.scl_v;
   assign OPT_STS.fault          = flt_s;
   assign OPT_STS.present        = ~prs_n_s;
   assign OPT_STS.fault_evt      = r.flt_evt;
   assign TWI_READY              = !r.busy;
   assign TWI_DONE               = r.done;
   assign TWI_RSP                = r.rsp;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   localparam int D_SET = tdroc_pkg::SETUP_CYC + 1;
   localparam int D_TAIL = tdroc_pkg::TAIL_CYC;
   localparam int D_TW1 = 4 * tdroc_pkg::TWI_QTR_CYC + 1;

   // Counts how long the decoder reset has been low
   logic [CW-1:0] low_cnt;
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST || TIMING_DECODER_RESET_N)
         low_cnt <= '0;
      else
         low_cnt <= low_cnt + 1'b1;
   end

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);

   sequence s_release;
      $rose(TIMING_DECODER_RESET_N) ##0 !GA_XLAT_OE_N;
   endsequence

   sequence s_fault_rise;
      $rose(OPT_TX_FAULT[0]);
   endsequence

   property p_req_rst;
      DEC_RST_REQ && !DEC_RST_BUSY |-> ##D_SET !TIMING_DECODER_RESET_N;
   endproperty
   a_req_rst: assert property (p_req_rst)
      else $error("decoder reset not asserted after request");

   property p_oe_cover;
      !TIMING_DECODER_RESET_N |-> !GA_XLAT_OE_N;
   endproperty
   a_oe_cover: assert property (p_oe_cover)
      else $error("translator off while decoder in reset");

   property p_setup;
      $fell(GA_XLAT_OE_N) |-> TIMING_DECODER_RESET_N [*8];
   endproperty
   a_setup: assert property (p_setup)
      else $error("reset asserted too soon after translator on");

   property p_hold;
      $rose(TIMING_DECODER_RESET_N) |-> low_cnt == tdroc_pkg::HOLD_CYC;
   endproperty
   a_hold: assert property (p_hold)
      else $error("decoder reset hold length wrong");

   property p_tail;
      s_release |-> ##D_TAIL GA_XLAT_OE_N;
   endproperty
   a_tail: assert property (p_tail)
      else $error("translator not released after reset");

   property p_laser;
      !$past(SRST) |->
         OPT_TX_DISABLE == ($past(LASER_OFF) | ~$past(OPT_STS.present));
   endproperty
   a_laser: assert property (p_laser)
      else $error("laser disable does not follow request");

   property p_fault;
      s_fault_rise |-> ##3 OPT_STS.fault_evt[0];
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault edge not reported");

   property p_present;
      OPT_STS.present == ~$past(MODULE_PRESENT_N, 2);
   endproperty
   a_present: assert property (p_present)
      else $error("presence status wrong");

   property p_lane;
      (~OPT_SDA_OE_N & ~(N'(1) << r.cmd.lane)) == '0;
   endproperty
   a_lane: assert property (p_lane)
      else $error("unselected socket data line driven");

   property p_start;
      TWI_REQ && TWI_READY && TWI_CMD.op == tdroc_pkg::TW_START
         |-> ##D_TW1 TWI_DONE;
   endproperty
   a_start: assert property (p_start)
      else $error("start condition timing wrong");

   property p_stop;
      TWI_DONE && r.cmd.op == tdroc_pkg::TW_STOP
         |-> OPT_SCL == '1 && OPT_SDA_OE_N == '1;
   endproperty
   a_stop: assert property (p_stop)
      else $error("bus not idle after stop");

endmodule

/* File: pkg/tdroc_pkg.sv */
// Shared constants and types for the decoder reset and optics control.
// Assumes one 100 MHz system clock with a synchronous active-high reset.
package tdroc_pkg;

   // ***********************************************************
   // Timing, all cycle counts derived from the clock rate
   // ***********************************************************
   localparam int CLK_MHZ     = 100;   // System clock rate
   localparam int SETUP_NS    = 100;   // Translator on before reset
   localparam int HOLD_NS     = 1000;  // Least decoder reset low time
   localparam int TAIL_NS     = 100;   // Translator on after release
   // Least times round up to whole cycles
   localparam int SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC    = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int TAIL_CYC    = (TAIL_NS * CLK_MHZ + 999) / 1000;
   localparam int SEQ_CW      = 8;     // Sequencer counter width
   // Serial clock may not exceed this rate, so the quarter rounds up
   localparam int TWI_KHZ     = 400;
   localparam int TWI_QTR_NS  = 1000000 / (4 * TWI_KHZ);
   localparam int TWI_QTR_CYC = (TWI_QTR_NS * CLK_MHZ + 999) / 1000;
   localparam int TWI_SLOTS   = 9;     // Eight data bits plus acknowledge

   // ***********************************************************
   // Sizes and reset values
   // ***********************************************************
   localparam int N_OPT       = 4;     // Optical transmitter sockets
   localparam int LANE_W      = 2;     // Socket index width
   localparam logic LINE_IDLE = 1'h1;  // Released serial line level

   // ***********************************************************
   // Types
   // ***********************************************************
   // Reset sequencer, Gray coded along the path
   typedef enum logic [1:0] {
      SQ_IDLE  = 2'h0,
      SQ_SETUP = 2'h1,
      SQ_HOLD  = 2'h3,
      SQ_TAIL  = 2'h2
   } tdroc_seq_e;

   // Power-up begins a decoder reset so the identity is always loaded
   localparam tdroc_seq_e SEQ_RST = SQ_SETUP;

   // Serial master operations
   typedef enum logic [1:0] {
      TW_START = 2'h0,
      TW_WRITE = 2'h1,
      TW_READ  = 2'h3,
      TW_STOP  = 2'h2
   } tdroc_op_e;

   typedef struct packed {
      tdroc_op_e          op;    // Operation
      logic               ack;   // Bit sent after a read byte
      logic [LANE_W-1:0]  lane;  // Target socket
      logic [7:0]         data;  // Byte to write
   } tdroc_cmd_s;

   typedef struct packed {
      logic [7:0] data;          // Byte seen on the line
      logic       nack;          // Acknowledge slot level
   } tdroc_rsp_s;

   typedef struct packed {
      logic [N_OPT-1:0] fault;     // Laser fault level
      logic [N_OPT-1:0] present;   // Module plugged in
      logic [N_OPT-1:0] fault_evt; // Fault rising edge pulse
   } tdroc_sts_s;

endpackage

/* File: testbench/tb.sv */
// Self-checking bench for the decoder reset and optics control.
// Assumes the socket model closes the serial and status pins.
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin \
   errors++; $display("unexpected at %0t: %s", $time, m); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic                  clk, srst, req, twi_req;
   logic [3:0]            laser_off, plug, flt, tx_dis, sda_out;
   logic [3:0]            sda_oe_n, scl, present_n, tx_fault, sda;
   logic                  rst_n, oe_n, busy, twi_ready, twi_done;
   tdroc_pkg::tdroc_cmd_s cmd;
   tdroc_pkg::tdroc_sts_s sts;
   tdroc_pkg::tdroc_rsp_s rsp;
   int                    errors, num_checks, cyc, lr, lo, lb, bad, n, c;
   logic [7:0]            b;
   tdroc_top dut (.CLK_SYS(clk), .SRST(srst), .DEC_RST_REQ(req),
      .TIMING_DECODER_RESET_N(rst_n), .GA_XLAT_OE_N(oe_n),
      .DEC_RST_BUSY(busy), .LASER_OFF(laser_off), .OPT_TX_DISABLE(tx_dis),
      .OPT_TX_FAULT(tx_fault), .MODULE_PRESENT_N(present_n),
      .OPT_SDA_IN(sda), .OPT_SDA_OUT(sda_out), .OPT_SDA_OE_N(sda_oe_n),
      .OPT_SCL(scl), .OPT_STS(sts), .TWI_REQ(twi_req), .TWI_CMD(cmd),
      .TWI_READY(twi_ready), .TWI_DONE(twi_done), .TWI_RSP(rsp));
   tdroc_opt_model opt (.scl(scl), .sda_oe_n(sda_oe_n), .plug(plug),
      .flt(flt), .present_n(present_n), .tx_fault(tx_fault), .sda(sda));
   // ***********************************************************
   // Clock and hang guard
   // ***********************************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         end_of_test();
      end
   end
   task automatic tick(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Counts reset-low, enable-low and busy cycles over a window;
   // reset low with the translator off is an ordering fault
   task automatic seq_meas(int win, logic drop);
      lr = 0; lo = 0; lb = 0; bad = 0;
      for (int i = 0; i < win; i++)
      begin
         tick(1);
         if (i == 2 && drop) req = 1'b0;
         lr += (rst_n === 1'b0);
         lo += (oe_n === 1'b0);
         lb += (busy === 1'b1);
         bad += (rst_n !== 1'b1 && oe_n !== 1'b0);
      end
   endtask
   // One serial command; latency from taking edge to done
   task automatic twi(tdroc_pkg::tdroc_op_e op, logic [1:0] ln,
                      logic [7:0] d, logic ak);
      int q;
      q = 4 * tdroc_pkg::TWI_QTR_CYC;
      cmd = '{op: op, ack: ak, lane: ln, data: d};
      twi_req = 1'b1;
      n = 0;
      while (twi_ready !== 1'b1 && n < 10) begin @(posedge clk); n++; end
      @(posedge clk);
      #1;
      twi_req = 1'b0;
      n = 1;
      while (twi_done !== 1'b1 && n < 3000) begin tick(1); n++; end
      if (op == tdroc_pkg::TW_WRITE || op == tdroc_pkg::TW_READ)
         q = q * tdroc_pkg::TWI_SLOTS;
      `CHK(n, q + 1, "serial latency")
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial
   begin
      srst = 1'b1; req = 1'b0; twi_req = 1'b0; cmd = '0;
      laser_off = 4'h0; plug = 4'hF; flt = 4'h0;
      void'($urandom(32'h5ECFDEC5));
      tick(6);
      `CHK(tx_dis, 4'hF, "laser on in reset")
      `CHK({scl, sda_oe_n}, 8'hFF, "serial lines in reset")
      srst = 1'b0;
      // Power-up decoder reset: length and translator ordering
      seq_meas(140, 1'b0);
      `CHK(lr, tdroc_pkg::HOLD_CYC, "power-up reset length")
      `CHK(bad, 0, "reset without translator")
      `CHK(oe_n, 1'b1, "translator left on")
      // Requested reset; request held while busy must be ignored
      req = 1'b1;
      seq_meas(140, 1'b1);
      c = tdroc_pkg::SETUP_CYC + tdroc_pkg::HOLD_CYC + tdroc_pkg::TAIL_CYC;
      `CHK(lr, tdroc_pkg::HOLD_CYC, "reset length")
      `CHK(lo, c, "translator window")
      `CHK(lb, c, "busy window")
      `CHK(bad, 0, "reset without translator")
      // Laser disable follows request and presence
      repeat (8)
      begin
         laser_off = 4'($urandom);
         plug = 4'($urandom);
         tick(4);
         `CHK(tx_dis, laser_off | ~plug, "laser disable")
         `CHK(sts.present, plug, "presence")
      end
      plug = 4'hF;
      laser_off = 4'h0;
      // One event pulse in total per fault rise, one socket raised at a time
      for (int i = 0; i < 4; i++)
      begin
         flt = 4'h1 << i;
         c = 0;
         repeat (6) begin tick(1); c += $countones(sts.fault_evt); end
         `CHK(c, 1, "fault event count")
         `CHK(sts.fault, flt, "fault level")
         flt = 4'h0;
         tick(4);
      end
      // Serial master: socket 0 answers, socket 1 stays silent
      for (int l = 0; l < 2; l++)
      begin
         b = 8'($urandom);
         twi(tdroc_pkg::TW_START, 2'(l), 8'h00, 1'b0);
         twi(tdroc_pkg::TW_WRITE, 2'(l), b, 1'b0);
         `CHK(rsp, {b, l != 0}, "write response")
         if (l == 0)
         begin
            twi(tdroc_pkg::TW_READ, 2'h0, 8'h00, 1'b1);
            `CHK(rsp, 9'h1FF, "read response")
         end
         twi(tdroc_pkg::TW_STOP, 2'(l), 8'h00, 1'b0);
         `CHK({scl, sda_oe_n}, 8'hFF, "bus idle after stop")
         `CHK(sda_out, 4'h0, "data line drives high")
      end
      end_of_test();
   end
endmodule

/* File: testbench/tdroc_opt_model.sv */
// Four optical sockets: presence, fault and a serial slave on socket 0.
// Assumes SDA has a pull-up; SCL is driven push-pull by the master.
module tdroc_opt_model (
   input  wire logic [3:0] scl,       // Serial clocks from master
   input  wire logic [3:0] sda_oe_n,  // Master pulls SDA when low
   input  wire logic [3:0] plug,      // Bench: module fitted
   input  wire logic [3:0] flt,       // Bench: laser fault
   output logic      [3:0] present_n, // Presence pins, low = fitted
   output logic      [3:0] tx_fault,  // Fault pins
   output logic      [3:0] sda        // Resolved data lines
);
   timeunit 1ns;
   timeprecision 100ps;
   int   bits;                        // SCL falls since start
   logic ack_drv;                     // Slave pulls SDA for acknowledge
   // ***********************************************************
   // Pins
   // ***********************************************************
   assign present_n = ~plug;
   assign tx_fault  = flt;
   // Open drain: pull-up wins unless someone pulls low
   assign sda = sda_oe_n & ~{3'h0, ack_drv};
   initial
   begin
      bits    = 0;
      ack_drv = 1'b0;
   end
   // Start condition restarts the slot count
   always @(negedge sda[0])
      if (scl[0] === 1'b1)
         bits = 0;
   // Ninth slot after the start frame carries the acknowledge
   always @(negedge scl[0])
   begin
      bits    = bits + 1;
      ack_drv = (bits == 9);
   end
endmodule
